// file: hw/ascp_pkg.sv
// Constants, register map and types of the axis stop and position counters.
// Assumes a 40 MHz reference clock and a 32-bit classic Wishbone register bus.
package ascp_pkg;
   // Clock and timing
   localparam int CLK_MHZ        = 40;
   localparam int STOP_PULSE_CYC = 8;
   localparam int FILT_NS        = 3000;
   localparam int FILT_CYC       = FILT_NS * CLK_MHZ / 1000;

   // Register byte addresses
   localparam logic [7:0] ADR_MODE = 8'h00;
   localparam logic [7:0] ADR_ENV1 = 8'h04;
   localparam logic [7:0] ADR_ENV2 = 8'h08;
   localparam logic [7:0] ADR_ENV3 = 8'h0C;
   localparam logic [7:0] ADR_CMD  = 8'h10;
   localparam logic [7:0] ADR_ERR  = 8'h14;
   localparam logic [7:0] ADR_STS  = 8'h18;
   localparam logic [7:0] ADR_CNT1 = 8'h1C;
   localparam logic [7:0] ADR_CNT2 = 8'h20;
   localparam logic [7:0] ADR_CNT3 = 8'h24;
   localparam logic [7:0] ADR_CNT4 = 8'h28;

   // Field positions
   localparam int MODE_WINP_BIT = 16;
   localparam int MODE_SPE_BIT  = 24;
   localparam int MODE_SPO_BIT  = 25;
   localparam int ENV1_ACT_BIT  = 19;
   localparam int ENV1_FLT_BIT  = 26;
   localparam int ENV2_EIM_LSB  = 20;
   localparam int ENV2_SWAP_BIT = 22;
   localparam int ENV2_DIS_BIT  = 30;
   localparam int ENV3_CI2_LSB  = 8;
   localparam int ENV3_CI3_LSB  = 10;
   localparam int ENV3_CI4_LSB  = 12;
   localparam int ERR_STOP_BIT  = 8;
   localparam int ERR_EMG_BIT   = 9;
   localparam int ERR_ENC_BIT   = 16;
   localparam int STS_RUN_BIT   = 0;
   localparam int STS_DEC_BIT   = 1;
   localparam int STS_WINP_BIT  = 2;
   localparam int STS_STOP_BIT  = 6;
   localparam int STS_EMG_BIT   = 7;

   // Writable bits and reset values
   localparam logic [31:0] MODE_MASK = 32'h0301_0000;
   localparam logic [31:0] ENV1_MASK = 32'h0408_0000;
   localparam logic [31:0] ENV2_MASK = 32'h4070_0000;
   localparam logic [31:0] ENV3_MASK = 32'h0000_3F00;
   localparam logic [31:0] ERR_MASK  = 32'h0001_0300;
   localparam logic [31:0] REG_RST   = 32'h0000_0000;

   // Commands
   localparam logic [7:0] CMD_EMG   = 8'h05;
   localparam logic [7:0] CMD_SPULS = 8'h07;
   localparam logic [7:0] CMD_START = 8'h50;

   typedef enum logic [1:0] {
      ENC_X1   = 2'b00,
      ENC_X2   = 2'b01,
      ENC_X4   = 2'b10,
      ENC_2PLS = 2'b11
   } ascp_enc_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN  = 2'b01,
      ST_STOP = 2'b11,
      ST_WINP = 2'b10
   } ascp_state_t;
endpackage

// file: hw/ascp_quad.sv
// Quadrature / two-pulse decoder giving up, down and error pulses.
// Assumes a_i and b_i are already synchronised to clk_i.
`timescale 1ns/1ps
module ascp_quad (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  a_i,
   input  wire logic                  b_i,
   input  wire logic [1:0]            mode_i,
   input  wire logic                  swap_i,
   input  wire logic                  dis_i,
   output logic                       up_o,
   output logic                       dn_o,
   output logic                       err_o
);
   typedef struct packed {
      logic pa;
      logic pb;
      logic up;
      logic dn;
      logic err;
   } ascp_quad_st_t;

   ascp_quad_st_t q;
   ascp_quad_st_t d;

   always_comb begin
      logic ar, af, br, bf, u, n, e;
      ar = a_i & ~q.pa;
      af = ~a_i & q.pa;
      br = b_i & ~q.pb;
      bf = ~b_i & q.pb;
      u = 1'b0;
      n = 1'b0;
      e = 1'b0;
      d = q;
      d.pa = a_i;
      d.pb = b_i;
      case (mode_i)
         ascp_pkg::ENC_X1: begin
            u = ar & ~b_i;
            n = af & ~b_i;
            e = (ar | af) & (br | bf);
         end
         ascp_pkg::ENC_X2: begin
            u = (ar & ~b_i) | (af & b_i);
            n = (ar & b_i) | (af & ~b_i);
            e = (ar | af) & (br | bf);
         end
         ascp_pkg::ENC_X4: begin
            u = (ar & ~b_i) | (af & b_i) | (br & a_i) | (bf & ~a_i);
            n = (ar & b_i) | (af & ~b_i) | (br & ~a_i) | (bf & a_i);
            e = (ar | af) & (br | bf);
         end
         ascp_pkg::ENC_2PLS: begin
            e = ar & br;
            u = ar & ~br;
            n = br & ~ar;
         end
         default: begin
            e = 1'b0;
         end
      endcase
      if (e) begin
         u = 1'b0;
         n = 1'b0;
      end
      d.up = ~dis_i & (swap_i ? n : u);
      d.dn = ~dis_i & (swap_i ? u : n);
      d.err = ~dis_i & e;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign up_o  = q.up;
   assign dn_o  = q.dn;
   assign err_o = q.err;
endmodule // ascp_quad

// file: hw/ascp_sync.sv
// Three-stage input synchroniser with optional glitch filter.
// Assumes async_i is a pin level outside the clk_i domain.
`timescale 1ns/1ps
module ascp_sync #(
   parameter int   FILT_CYC = ascp_pkg::FILT_CYC,
   parameter logic RST_VAL  = 1'b0
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic async_i,
   input  wire logic filt_en_i,
   output logic      level_o
);
   localparam int CW = $clog2(FILT_CYC + 1);
   if (FILT_CYC < 1) begin : g_chk
      $error("ascp_sync: FILT_CYC must be at least 1");
   end

   typedef struct packed {
      logic [2:0]    s;
      logic [CW-1:0] cnt;
      logic          lvl;
   } ascp_sync_st_t;

   ascp_sync_st_t q;
   ascp_sync_st_t d;

   always_comb begin
      d = q;
      d.s = {q.s[1:0], async_i};
      // Change accepted once second and third stages agree, or FILT_CYC cycles after that when the filter is enabled
      if ((q.s[1] == q.s[2]) && (q.s[2] != q.lvl)) begin
         if (!filt_en_i || (q.cnt == CW'(FILT_CYC))) begin
            d.lvl = q.s[2];
            d.cnt = '0;
         end else begin
            d.cnt = q.cnt + CW'(1);
         end
      end else begin
         d.cnt = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '{s: {3{RST_VAL}}, cnt: '0, lvl: RST_VAL};
      end else begin
         q <= d;
      end
   end

   assign level_o = q.lvl;
endmodule // ascp_sync

// file: hw/ascp_top.sv
// Axis stop handling and position counters with a Wishbone slave.
// Assumes a pulse generator on clk_i that reports pulse-cycle end and
// move completion, and open-drain shared stop and emergency lines.
//
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module ascp_top #(
   parameter int CNT_W = 28,
   parameter int DEV_W = 16
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        shared_stop_line_i,
   output logic             shared_stop_line_o,
   output logic             shared_stop_line_oe_o,
   input  wire logic        shared_emergency_line_i,
   input  wire logic        in_position_input_i,
   input  wire logic        enc_phase_a_i,
   input  wire logic        enc_phase_b_i,
   input  wire logic        pulser_phase_a_i,
   input  wire logic        pulser_phase_b_i,
   input  wire logic        cmd_pulse_i,
   input  wire logic        cmd_dir_i,
   input  wire logic        pulse_cycle_end_i,
   input  wire logic        move_done_i,
   output logic             axis_busy_o,
   output logic             axis_start_o,
   output logic             axis_decel_o,
   output logic             axis_halt_o
);
   if (CNT_W < 4 || CNT_W > 32 || DEV_W < 4 || DEV_W > CNT_W) begin : g_chk
      $error("ascp_top: counter widths out of range");
   end

   typedef struct packed {
      logic                   ack;
      logic [31:0]            rdat;
      logic [31:0]            mode;
      logic [31:0]            env1;
      logic [31:0]            env2;
      logic [31:0]            env3;
      logic [31:0]            err;
      ascp_pkg::ascp_state_t  st;
      logic [3:0]             spcnt;
      logic                   sp_oe;
      logic                   stop_prev;
      logic                   decel;
      logic                   halt;
      logic                   start;
      logic                   busy;
      logic                   half;
      logic [CNT_W-1:0]       c1;
      logic [CNT_W-1:0]       c2;
      logic [DEV_W-1:0]       c3;
      logic [CNT_W-1:0]       c4;
   } ascp_top_st_t;

   ascp_top_st_t q;
   ascp_top_st_t d;

   // Synchronised pins: stop, emergency, in-position, enc A/B, pulser A/B
   localparam int         NSYNC    = 7;
   localparam logic [6:0] FILT_SEL = 7'b0000110;
   localparam logic [6:0] RST_SEL  = 7'b0000011;
   logic [NSYNC-1:0] raw;
   logic [NSYNC-1:0] lvl;
   assign raw = {pulser_phase_b_i, pulser_phase_a_i, enc_phase_b_i,
                 enc_phase_a_i, in_position_input_i,
                 shared_emergency_line_i, shared_stop_line_i};

   genvar gi;
   for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      ascp_sync #(
         .FILT_CYC (ascp_pkg::FILT_CYC),
         .RST_VAL  (RST_SEL[gi])
      ) u_sync (
         .clk_i     (clk_i),
         .rst_i     (rst_i),
         .async_i   (raw[gi]),
         .filt_en_i (FILT_SEL[gi] & q.env1[ascp_pkg::ENV1_FLT_BIT]),
         .level_o   (lvl[gi])
      );
   end

   logic stop_lvl;
   logic emg_lvl;
   logic inp_lvl;
   assign stop_lvl = lvl[0];
   assign emg_lvl  = lvl[1];
   assign inp_lvl  = lvl[2];

   logic enc_up, enc_dn, enc_err;
   logic pls_up, pls_dn;

   ascp_quad u_enc (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .a_i    (lvl[3]),
      .b_i    (lvl[4]),
      .mode_i (q.env2[ascp_pkg::ENV2_EIM_LSB +: 2]),
      .swap_i (q.env2[ascp_pkg::ENV2_SWAP_BIT]),
      .dis_i  (q.env2[ascp_pkg::ENV2_DIS_BIT]),
      .up_o   (enc_up),
      .dn_o   (enc_dn),
      .err_o  (enc_err)
   );

   ascp_quad u_pls (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .a_i    (lvl[5]),
      .b_i    (lvl[6]),
      .mode_i (ascp_pkg::ENC_X4),
      .swap_i (1'b0),
      .dis_i  (1'b0),
      .up_o   (pls_up),
      .dn_o   (pls_dn),
      .err_o  ()
   );

   // Byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel,
                                         input logic [31:0] msk);
      logic [31:0] be;
      be = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & msk;
      return (old & ~be) | (nw & be);
   endfunction

   // Signed step of -1, 0 or +1 from an up/down pair
   function automatic logic signed [2:0] step(input logic up,
                                              input logic dn);
      return 3'(signed'({2'b00, up})) - 3'(signed'({2'b00, dn}));
   endfunction

   function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v,
                                             input logic signed [2:0] s);
      return v + {{(CNT_W-3){s[2]}}, s};
   endfunction

   always_comb begin
      logic take, wr, cmd_wr, emg_cmd, sp_cmd, start_cmd;
      logic stop_fall, emg_on, abn, active;
      logic [31:0] err_set, err_clr, rd;
      logic signed [2:0] s_cmd, s_enc, s_pls, s2, s3, s4;
      d = q;
      d.halt = 1'b0;
      d.start = 1'b0;
      take = wb_cyc_i & wb_stb_i & ~q.ack;
      wr = take & wb_we_i;
      d.ack = take;
      cmd_wr = wr & (wb_adr_i == ascp_pkg::ADR_CMD) & wb_sel_i[0];
      emg_cmd = cmd_wr & (wb_dat_i[7:0] == ascp_pkg::CMD_EMG);
      sp_cmd = cmd_wr & (wb_dat_i[7:0] == ascp_pkg::CMD_SPULS);
      start_cmd = cmd_wr & (wb_dat_i[7:0] == ascp_pkg::CMD_START);
      err_set = '0;
      err_clr = '0;
      abn = 1'b0;
      active = (q.st != ascp_pkg::ST_IDLE);
      emg_on = ~emg_lvl;
      d.stop_prev = stop_lvl;
      stop_fall = q.stop_prev & ~stop_lvl & q.mode[ascp_pkg::MODE_SPE_BIT];

      // Axis state
      if (active && (emg_on || emg_cmd)) begin
         d.st = ascp_pkg::ST_IDLE;
         d.decel = 1'b0;
         d.halt = 1'b1;
         abn = 1'b1;
         err_set[ascp_pkg::ERR_EMG_BIT] = emg_on;
      end else begin
         case (q.st)
            ascp_pkg::ST_IDLE: begin
               if (start_cmd && !emg_on) begin
                  if (q.mode[ascp_pkg::MODE_SPE_BIT] && !stop_lvl) begin
                     err_set[ascp_pkg::ERR_STOP_BIT] = 1'b1;
                     abn = 1'b1;
                  end else begin
                     d.st = ascp_pkg::ST_RUN;
                     d.start = 1'b1;
                  end
               end
            end
            ascp_pkg::ST_RUN: begin
               if (stop_fall) begin
                  err_set[ascp_pkg::ERR_STOP_BIT] = 1'b1;
                  abn = 1'b1;
                  d.st = ascp_pkg::ST_STOP;
                  d.decel = q.env1[ascp_pkg::ENV1_ACT_BIT];
               end else if (move_done_i) begin
                  d.st = q.mode[ascp_pkg::MODE_WINP_BIT] ?
                         ascp_pkg::ST_WINP : ascp_pkg::ST_IDLE;
               end
            end
            ascp_pkg::ST_STOP: begin
               if (q.decel ? move_done_i : pulse_cycle_end_i) begin
                  d.st = ascp_pkg::ST_IDLE;
                  d.halt = ~q.decel;
                  d.decel = 1'b0;
               end
            end
            ascp_pkg::ST_WINP: begin
               if (inp_lvl) begin
                  d.st = ascp_pkg::ST_IDLE;
               end
            end
            default: begin
               d.st = ascp_pkg::ST_IDLE;
            end
         endcase
      end

      d.busy = (d.st != ascp_pkg::ST_IDLE);

      // Open-drain one-shot on the shared stop line
      if (q.spcnt != 4'h0) begin
         d.spcnt = q.spcnt - 4'h1;
      end else if (sp_cmd ||
                   (abn && q.mode[ascp_pkg::MODE_SPO_BIT])) begin
         d.spcnt = 4'(ascp_pkg::STOP_PULSE_CYC);
      end
      d.sp_oe = (d.spcnt != 4'h0);

      // Counters
      err_set[ascp_pkg::ERR_ENC_BIT] = enc_err;
      d.half = ~q.half;
      s_cmd = step(cmd_pulse_i & cmd_dir_i, cmd_pulse_i & ~cmd_dir_i);
      s_enc = step(enc_up, enc_dn);
      s_pls = step(pls_up, pls_dn);
      case (q.env3[ascp_pkg::ENV3_CI2_LSB +: 2])
         2'b00:   s2 = s_enc;
         2'b01:   s2 = s_cmd;
         2'b10:   s2 = s_pls;
         default: s2 = 3'sd0;
      endcase
      case (q.env3[ascp_pkg::ENV3_CI3_LSB +: 2])
         2'b00:   s3 = s_cmd - s_enc;
         2'b01:   s3 = s_cmd - s_pls;
         2'b10:   s3 = s_enc - s_pls;
         default: s3 = 3'sd0;
      endcase
      case (q.env3[ascp_pkg::ENV3_CI4_LSB +: 2])
         2'b00:   s4 = s_cmd;
         2'b01:   s4 = s_enc;
         2'b10:   s4 = s_pls;
         default: s4 = step(q.half, 1'b0);
      endcase
      d.c1 = bump(q.c1, s_cmd);
      d.c2 = bump(q.c2, s2);
      d.c3 = DEV_W'(bump(CNT_W'(q.c3), s3));
      d.c4 = bump(q.c4, s4);

      // Register writes
      if (wr) begin
         case (wb_adr_i)
            ascp_pkg::ADR_MODE:
               d.mode = merge(q.mode, wb_dat_i, wb_sel_i, ascp_pkg::MODE_MASK);
            ascp_pkg::ADR_ENV1:
               d.env1 = merge(q.env1, wb_dat_i, wb_sel_i, ascp_pkg::ENV1_MASK);
            ascp_pkg::ADR_ENV2:
               d.env2 = merge(q.env2, wb_dat_i, wb_sel_i, ascp_pkg::ENV2_MASK);
            ascp_pkg::ADR_ENV3:
               d.env3 = merge(q.env3, wb_dat_i, wb_sel_i, ascp_pkg::ENV3_MASK);
            ascp_pkg::ADR_ERR:
               err_clr = merge('0, wb_dat_i, wb_sel_i, ascp_pkg::ERR_MASK);
            ascp_pkg::ADR_CNT1:
               d.c1 = CNT_W'(merge(32'(q.c1), wb_dat_i, wb_sel_i, '1));
            ascp_pkg::ADR_CNT2:
               d.c2 = CNT_W'(merge(32'(q.c2), wb_dat_i, wb_sel_i, '1));
            ascp_pkg::ADR_CNT3:
               d.c3 = DEV_W'(merge(32'(q.c3), wb_dat_i, wb_sel_i, '1));
            ascp_pkg::ADR_CNT4:
               d.c4 = CNT_W'(merge(32'(q.c4), wb_dat_i, wb_sel_i, '1));
            default: begin
               d.mode = q.mode;
            end
         endcase
      end
      // Hardware set wins over software clear
      d.err = (q.err & ~err_clr) | err_set;

      // Register reads
      rd = '0;
      case (wb_adr_i)
         ascp_pkg::ADR_MODE: rd = q.mode;
         ascp_pkg::ADR_ENV1: rd = q.env1;
         ascp_pkg::ADR_ENV2: rd = q.env2;
         ascp_pkg::ADR_ENV3: rd = q.env3;
         ascp_pkg::ADR_ERR:  rd = q.err;
         ascp_pkg::ADR_STS: begin
            rd[ascp_pkg::STS_RUN_BIT]  = active;
            rd[ascp_pkg::STS_DEC_BIT]  = q.decel;
            rd[ascp_pkg::STS_WINP_BIT] = (q.st == ascp_pkg::ST_WINP);
            rd[ascp_pkg::STS_STOP_BIT] = ~stop_lvl;
            rd[ascp_pkg::STS_EMG_BIT]  = emg_on;
         end
         ascp_pkg::ADR_CNT1: rd = 32'(q.c1);
         ascp_pkg::ADR_CNT2: rd = 32'(q.c2);
         ascp_pkg::ADR_CNT3: rd = 32'(q.c3);
         ascp_pkg::ADR_CNT4: rd = 32'(q.c4);
         default:            rd = '0;
      endcase
      d.rdat = take ? rd : '0;
   end

   // Emergency stop touches no configuration or counter state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '{st: ascp_pkg::ST_IDLE, stop_prev: 1'b1,
                mode: ascp_pkg::REG_RST, env1: ascp_pkg::REG_RST,
                env2: ascp_pkg::REG_RST, env3: ascp_pkg::REG_RST,
                err: ascp_pkg::REG_RST, default: '0};
      end else begin
         q <= d;
      end
   end

   assign wb_dat_o              = q.rdat;
   assign wb_ack_o              = q.ack;
   assign shared_stop_line_o    = 1'b0;
   assign shared_stop_line_oe_o = q.sp_oe;
   assign axis_busy_o           = q.busy;
   assign axis_start_o          = q.start;
   assign axis_decel_o          = q.decel;
   assign axis_halt_o           = q.halt;
endmodule // ascp_top

// file: sim/ascp_peer_model.sv
// Peer chips, external stop source and encoder on the far side.
// Assumes both shared lines have pull-ups; tasks start after a clock edge.
`timescale 1ns/1ps
module ascp_peer_model (
   input  wire logic clk_i,
   input  wire logic dut_oe_i,
   output logic      stop_line_o,
   output logic      emg_line_o,
   output logic      enc_a_o = 1'b0,
   output logic      enc_b_o = 1'b0
);
   logic ext_pull = 1'b0;
   logic emg_pull = 1'b0;
   // Open drain: low while any party pulls
   assign stop_line_o = !(dut_oe_i || ext_pull);
   assign emg_line_o = !emg_pull;
   task automatic stop_pulse();
      ext_pull <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_pull <= 1'b0;
   endtask
   task automatic emg(input logic on);
      emg_pull <= on;
      @(posedge clk_i);
   endtask
   task automatic step(input logic a, input logic b);
      enc_a_o <= a;
      enc_b_o <= b;
      repeat (8) @(posedge clk_i);
   endtask
endmodule // ascp_peer_model

// file: sim/ascp_top_properties.sv
// Port checker for the axis stop and position counters top.
// Assumes it is bound onto ascp_top; rst_i is synchronous.
`timescale 1ns/1ps
module ascp_top_properties (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        shared_stop_line_o,
   input wire logic        shared_stop_line_oe_o,
   input wire logic        shared_emergency_line_i,
   input wire logic        axis_busy_o,
   input wire logic        axis_start_o,
   input wire logic        axis_decel_o,
   input wire logic        axis_halt_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [7:0] emg_low_q;
   // Cycles the emergency line has been low
   always_ff @(posedge clk_i) begin
      if (rst_i || shared_emergency_line_i) emg_low_q <= 8'h00;
      else if (emg_low_q != 8'hFF) emg_low_q <= emg_low_q + 8'h01;
   end
   ack_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("request not acked");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data without ack");
   pulse_len_a: assert property ($rose(shared_stop_line_oe_o) |->
      shared_stop_line_oe_o[*8] ##1 !shared_stop_line_oe_o)
      else $error("stop pulse width wrong");
   line_low_a: assert property (!shared_stop_line_o)
      else $error("stop line driven high");
   emg_hold_a: assert property (emg_low_q == 8'hC8 |->
      !axis_busy_o && !axis_start_o) else $error("axis runs in emergency");
   halt_single_a: assert property (axis_halt_o |=> !axis_halt_o)
      else $error("halt too long");
   start_busy_a: assert property (axis_start_o |-> axis_busy_o)
      else $error("start without busy");
   decel_busy_a: assert property (axis_decel_o |-> axis_busy_o)
      else $error("decel while idle");
endmodule // ascp_top_properties

bind ascp_top ascp_top_properties ascp_top_properties_inst (.clk_i,
   .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
   .shared_stop_line_o, .shared_stop_line_oe_o, .shared_emergency_line_i,
   .axis_busy_o, .axis_start_o, .axis_decel_o, .axis_halt_o);

// file: sim/tb.sv
// Self-checking bench for the axis stop and position counters.
// Assumes the peer model drives the shared lines and the encoder.
`timescale 1ns/1ps
module tb;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0, wb_ack_o, cmd_pulse_i = 1'b0, move_done_i = 1'b0;
   logic pulse_cycle_end_i = 1'b0, shared_stop_line_i, shared_stop_line_o;
   logic shared_stop_line_oe_o, shared_emergency_line_i, enc_phase_a_i;
   logic enc_phase_b_i, axis_busy_o, axis_start_o, axis_decel_o, axis_halt_o;
   logic in_position_input_i = 1'b0, cmd_dir_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
   int fail_count = 0, num_checks = 0, cycles = 0, oe_cnt = 0, base, m, s;
   ascp_top ascp_top_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .shared_stop_line_i, .shared_stop_line_o, .shared_stop_line_oe_o,
      .shared_emergency_line_i, .in_position_input_i, .enc_phase_a_i,
      .enc_phase_b_i, .pulser_phase_a_i(1'b0), .pulser_phase_b_i(1'b0),
      .cmd_pulse_i, .cmd_dir_i, .pulse_cycle_end_i, .move_done_i,
      .axis_busy_o, .axis_start_o, .axis_decel_o, .axis_halt_o);
   ascp_peer_model ascp_peer_model_inst (.clk_i,
      .dut_oe_i(shared_stop_line_oe_o), .stop_line_o(shared_stop_line_i),
      .emg_line_o(shared_emergency_line_i), .enc_a_o(enc_phase_a_i),
      .enc_b_o(enc_phase_b_i));
   initial forever #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      oe_cnt <= oe_cnt + int'(shared_stop_line_oe_o);
      pulse_cycle_end_i <= (cycles[1:0] == 2'b00);
      if (cycles == 8000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s exp %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      chk($sformatf("reg %h", a), q, e);
   endtask
   task automatic cmd(input logic [7:0] c);
      wb(1'b1, ascp_pkg::ADR_CMD, {24'h000000, c});
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic quad(input logic fwd);
      ascp_peer_model_inst.step(fwd, !fwd);
      ascp_peer_model_inst.step(1'b1, 1'b1);
      ascp_peer_model_inst.step(!fwd, fwd);
      ascp_peer_model_inst.step(1'b0, 1'b0);
   endtask
   initial begin
      wait_cyc(8);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(ascp_pkg::ADR_STS, 32'h0000_0000);
      rd(8'h3C, 32'h0000_0000);
      wb(1'b1, ascp_pkg::ADR_ENV3, 32'hFFFF_FFFF);
      rd(ascp_pkg::ADR_ENV3, 32'h0000_3F00);
      $display("test reset done");
      wb(1'b1, ascp_pkg::ADR_MODE, 32'h0100_0000);
      cmd(ascp_pkg::CMD_START);
      rd(ascp_pkg::ADR_STS, 32'h0000_0001);
      base = oe_cnt;
      cmd(ascp_pkg::CMD_SPULS);
      wait_cyc(30);
      chk("pulse cycles", 32'(oe_cnt - base), 32'h8);
      rd(ascp_pkg::ADR_ERR, 32'h0000_0100);
      rd(ascp_pkg::ADR_STS, 32'h0000_0000);
      wb(1'b1, ascp_pkg::ADR_ERR, 32'h0000_0100);
      wb(1'b1, ascp_pkg::ADR_ENV1, 32'h0008_0000);
      cmd(ascp_pkg::CMD_START);
      ascp_peer_model_inst.stop_pulse();
      wait_cyc(10);
      rd(ascp_pkg::ADR_STS, 32'h0000_0003);
      move_done_i <= 1'b1;
      @(posedge clk_i);
      move_done_i <= 1'b0;
      rd(ascp_pkg::ADR_STS, 32'h0000_0000);
      rd(ascp_pkg::ADR_ERR, 32'h0000_0100);
      wb(1'b1, ascp_pkg::ADR_ERR, 32'h0000_0100);
      $display("test stop line done");
      cmd(ascp_pkg::CMD_START);
      base = oe_cnt;
      ascp_peer_model_inst.emg(1'b1);
      wait_cyc(210);
      cmd(ascp_pkg::CMD_START);
      rd(ascp_pkg::ADR_STS, 32'h0000_0080);
      rd(ascp_pkg::ADR_ERR, 32'h0000_0200);
      chk("no auto pulse", 32'(oe_cnt - base), 32'h0);
      ascp_peer_model_inst.emg(1'b0);
      wait_cyc(8);
      wb(1'b1, ascp_pkg::ADR_ERR, 32'h0000_0200);
      wb(1'b1, ascp_pkg::ADR_MODE, 32'h0301_0000);
      cmd(ascp_pkg::CMD_START);
      move_done_i <= 1'b1;
      @(posedge clk_i);
      move_done_i <= 1'b0;
      rd(ascp_pkg::ADR_STS, 32'h0000_0005);
      base = oe_cnt;
      cmd(ascp_pkg::CMD_EMG);
      wait_cyc(30);
      rd(ascp_pkg::ADR_STS, 32'h0000_0000);
      chk("auto pulse", 32'(oe_cnt - base), 32'h8);
      rd(ascp_pkg::ADR_MODE, 32'h0301_0000);
      rd(ascp_pkg::ADR_ERR, 32'h0000_0000);
      wb(1'b1, ascp_pkg::ADR_ENV3, 32'h0000_0000);
      $display("test emergency done");
      for (m = 0; m < 6; m++) begin
         s = m / 3;
         wb(1'b1, ascp_pkg::ADR_ENV2, 32'((m % 3) << 20 | s << 22));
         wb(1'b1, ascp_pkg::ADR_CNT2, 32'h0000_0000);
         quad(1'b1);
         base = 1 << (m % 3);
         rd(ascp_pkg::ADR_CNT2, s ? 32'h1000_0000 - base : base);
      end
      wb(1'b1, ascp_pkg::ADR_ENV2, 32'h0000_0000);
      wb(1'b1, ascp_pkg::ADR_CNT2, 32'h0000_0000);
      quad(1'b0);
      rd(ascp_pkg::ADR_CNT2, 32'h0FFF_FFFF);
      wb(1'b1, ascp_pkg::ADR_ENV2, 32'h0030_0000);
      wb(1'b1, ascp_pkg::ADR_CNT2, 32'h0000_0000);
      ascp_peer_model_inst.step(1'b1, 1'b0);
      ascp_peer_model_inst.step(1'b0, 1'b0);
      quad(1'b1);
      rd(ascp_pkg::ADR_CNT2, 32'h0000_0001);
      wb(1'b1, ascp_pkg::ADR_ENV2, 32'h4000_0000);
      wb(1'b1, ascp_pkg::ADR_CNT2, 32'h0000_0000);
      quad(1'b1);
      rd(ascp_pkg::ADR_CNT2, 32'h0000_0000);
      wb(1'b1, ascp_pkg::ADR_ENV2, 32'h0000_0000);
      cmd(ascp_pkg::CMD_START);
      ascp_peer_model_inst.step(1'b1, 1'b1);
      ascp_peer_model_inst.step(1'b0, 1'b0);
      rd(ascp_pkg::ADR_ERR, 32'h0001_0000);
      rd(ascp_pkg::ADR_STS, 32'h0000_0001);
      in_position_input_i <= 1'b1;
      move_done_i <= 1'b1;
      @(posedge clk_i);
      move_done_i <= 1'b0;
      wait_cyc(8);
      rd(ascp_pkg::ADR_STS, 32'h0000_0000);
      $display("test encoder done");
      wb(1'b1, ascp_pkg::ADR_ENV3, 32'h0000_0100);
      for (m = 0; m < 4; m++) wb(1'b1, 8'(28 + 4 * m), 32'h0000_0000);
      repeat (5) begin
         cmd_pulse_i <= 1'b1;
         @(posedge clk_i);
         cmd_pulse_i <= 1'b0;
         cmd_dir_i <= ~cmd_dir_i;
         wait_cyc(2);
      end
      wait_cyc(4);
      for (m = 0; m < 4; m++)
         rd(8'(28 + 4 * m), m == 2 ? 32'h0000_FFFF : 32'h0FFF_FFFF);
      wb(1'b1, ascp_pkg::ADR_ENV3, 32'h0000_3F00);
      wb(1'b1, ascp_pkg::ADR_CNT4, 32'h0000_0000);
      wait_cyc(20);
      wb(1'b0, ascp_pkg::ADR_CNT4, 32'h0000_0000);
      chk("half clock", 32'(q inside {[10:13]}), 32'h1);
      rd(ascp_pkg::ADR_CNT2, 32'h0FFF_FFFF);
      $display("test counters done");
      wrap_up();
   end
endmodule // tb
